// File: rtl/bcb_map.svh
// Constants for the bit-clear and conditional branch execute block.
// How it works
// - Bit-clear zeroes one bit, keeps the rest.
// - Access flag zero: access bank; one: bank select.
// - Extended set, flag zero, address <= 5Fh: indexed.
// - None of these instructions alters status flags.
// - Branch on negative when negative flag is one.
// - Branch on no carry when carry is zero.
// - Branch on not negative when negative is zero.
// - Branch on no overflow when overflow is zero.
// - Branch on nonzero when zero flag is zero.
// - Taken: PC gets incremented PC plus twice offset.
// - Taken branch adds one all-idle cycle.
// - Not taken: idle fourth phase, continue at PC+2.
`ifndef BCB_MAP_SVH
`define BCB_MAP_SVH

`define BCB_OP_BIT_CLEAR      4'h9
`define BCB_OP_BRANCH_NEG     8'hE6
`define BCB_OP_BRANCH_NO_C    8'hE3
`define BCB_OP_BRANCH_NOT_NEG 8'hE7
`define BCB_OP_BRANCH_NO_OV   8'hE5
`define BCB_OP_BRANCH_NONZERO 8'hE1
`define BCB_OP_NOP            16'h0000

`define BCB_IDX_MAX           8'h5F
`define BCB_ACC_SPLIT         8'h60
`define BCB_ACC_LO_BANK       4'h0
`define BCB_ACC_HI_BANK       4'hF

`define BCB_BIT_POS_HI        11
`define BCB_BIT_POS_LO        9
`define BCB_ACCESS_BIT        8

`define BCB_PC_W              21
`define BCB_DADDR_W           12
`define BCB_PC_RESET          21'h000000
`define BCB_DADDR_RESET       12'h000
`define BCB_DATA_RESET        8'h00

`endif

// File: rtl/bcb_pkg.sv
// Types shared by the bit-clear and conditional branch execute block.
package bcb_pkg;

  // Q phases in Gray order so one bit changes per clock.
  typedef enum logic [1:0] {
    BCB_Q1 = 2'b00,
    BCB_Q2 = 2'b01,
    BCB_Q3 = 2'b11,
    BCB_Q4 = 2'b10
  } bcb_phase_t;

endpackage

// File: rtl/bcb_addr_if.sv
// Operand address request between the execute core and its address unit.
`timescale 1ns/10ps
interface bcb_addr_if;
  logic [7:0]  f;
  logic        acc_sel;
  logic [3:0]  bank;
  logic        ext_en;
  logic [11:0] fsr2;
  logic [11:0] addr;
  logic        indexed;

  modport gen  (input f, acc_sel, bank, ext_en, fsr2,
                output addr, indexed);
  modport user (output f, acc_sel, bank, ext_en, fsr2,
                input addr, indexed);
endinterface

// File: rtl/bcb_addr_gen.sv
// Data memory address generation for the bit-clear instruction.
`timescale 1ns/10ps
`include "bcb_map.svh"
module bcb_addr_gen
  import bcb_pkg::*;
(
  bcb_addr_if.gen ai
);

  wire        idx_hit;
  wire        acc_low;
  wire [11:0] acc_addr;
  wire [11:0] bank_addr;
  wire [11:0] idx_addr;

  assign idx_hit   = ~ai.acc_sel & ai.ext_en
                     & (ai.f <= `BCB_IDX_MAX);
  assign acc_low   = ai.f < `BCB_ACC_SPLIT;
  assign acc_addr  = acc_low ? {`BCB_ACC_LO_BANK, ai.f}
                             : {`BCB_ACC_HI_BANK, ai.f};
  assign bank_addr = {ai.bank, ai.f};
  assign idx_addr  = ai.fsr2 + {4'h0, ai.f};

  assign ai.addr    = idx_hit    ? idx_addr :
                      ai.acc_sel ? bank_addr : acc_addr;
  assign ai.indexed = idx_hit;

endmodule // bcb_addr_gen

// File: rtl/bcb_exec.sv
// Execute core for bit-clear and five conditional relative branches.
`timescale 1ns/10ps
`include "bcb_map.svh"
module bcb_exec
  import bcb_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [15:0]             instr,
  input  wire logic                    ext_en,
  input  wire logic [3:0]              bank_select_register,
  input  wire logic [11:0]             fsr2,
  input  wire logic                    flag_n,
  input  wire logic                    flag_ov,
  input  wire logic                    flag_c,
  input  wire logic                    flag_z,
  input  wire logic [`BCB_PC_W-1:0]    pc_inc,
  input  wire logic [7:0]              dmem_rdata,
  output logic [1:0]                   q_phase,
  output logic [`BCB_DADDR_W-1:0]      dmem_addr,
  output logic                         dmem_rd,
  output logic                         dmem_wr,
  output logic [7:0]                   dmem_wdata,
  output logic [`BCB_PC_W-1:0]         pc_next,
  output logic                         pc_load,
  output logic                         nop_cycle,
  output logic                         status_we
);

  ////////////////////////////////////////////////////////////////////////
  // Phase sequencer and instruction capture.

  bcb_phase_t              q_reg;
  bcb_phase_t              q_next;
  logic [15:0]             ir_reg;
  logic [3:0]              flags_reg;
  logic [`BCB_PC_W-1:0]    pc_base_reg;
  logic                    nop_reg;

  always_comb begin
    case (q_reg)
      BCB_Q1:  q_next = BCB_Q2;
      BCB_Q2:  q_next = BCB_Q3;
      BCB_Q3:  q_next = BCB_Q4;
      BCB_Q4:  q_next = BCB_Q1;
      default: q_next = BCB_Q1;
    endcase
  end

  wire ph1 = (q_reg == BCB_Q1);
  wire ph2 = (q_reg == BCB_Q2);
  wire ph3 = (q_reg == BCB_Q3);
  wire ph4 = (q_reg == BCB_Q4);

  // The idle cycle after a taken branch decodes a forced no-operation.
  wire [15:0] ir_next = nop_reg ? `BCB_OP_NOP : instr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg       <= BCB_Q1;
      ir_reg      <= `BCB_OP_NOP;
      flags_reg   <= 4'h0;
      pc_base_reg <= `BCB_PC_RESET;
    end else begin
      q_reg <= q_next;
      if (ph1) begin
        ir_reg      <= ir_next;
        flags_reg   <= {flag_n, flag_ov, flag_c, flag_z};
        pc_base_reg <= pc_inc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand address for the bit-clear read and write.

  bcb_addr_if ai ();

  assign ai.f       = instr[7:0];
  assign ai.acc_sel = instr[`BCB_ACCESS_BIT];
  assign ai.bank    = bank_select_register;
  assign ai.ext_en  = ext_en;
  assign ai.fsr2    = fsr2;

  bcb_addr_gen u_addr_gen (
    .ai (ai.gen)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode of the latched instruction; bcf_in decodes the incoming one.

  wire       fn = flags_reg[3];
  wire       fv = flags_reg[2];
  wire       fc = flags_reg[1];
  wire       fz = flags_reg[0];
  wire [7:0] hi = ir_reg[15:8];

  wire bcf_in   = (ir_next[15:12] == `BCB_OP_BIT_CLEAR);
  wire is_bcf   = (ir_reg[15:12] == `BCB_OP_BIT_CLEAR);
  wire take_n   = (hi == `BCB_OP_BRANCH_NEG)      &  fn;
  wire take_nc  = (hi == `BCB_OP_BRANCH_NO_C)     & ~fc;
  wire take_nn  = (hi == `BCB_OP_BRANCH_NOT_NEG)  & ~fn;
  wire take_nov = (hi == `BCB_OP_BRANCH_NO_OV)    & ~fv;
  wire take_nz  = (hi == `BCB_OP_BRANCH_NONZERO)  & ~fz;
  wire is_br    = (hi == `BCB_OP_BRANCH_NEG) | (hi == `BCB_OP_BRANCH_NO_C)
                | (hi == `BCB_OP_BRANCH_NOT_NEG)
                | (hi == `BCB_OP_BRANCH_NO_OV)
                | (hi == `BCB_OP_BRANCH_NONZERO);
  wire taken    = take_n | take_nc | take_nn | take_nov | take_nz;

  wire [`BCB_PC_W-1:0] br_off = {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
  wire [`BCB_PC_W-1:0] target = pc_base_reg + br_off;

  wire [7:0] clr_mask = ~(8'h01 << ir_reg[`BCB_BIT_POS_HI:`BCB_BIT_POS_LO]);

  ////////////////////////////////////////////////////////////////////////
  // Bit-clear data path: read in Q2, modify in Q3, write in Q4.

  logic [7:0]                data_reg;
  logic [`BCB_DADDR_W-1:0]   dmem_addr_reg;
  logic                      dmem_rd_reg;
  logic                      dmem_wr_reg;
  logic [7:0]                dmem_wdata_reg;

  wire dmem_rd_next = ph1 & bcf_in;
  wire dmem_wr_next = ph3 & is_bcf;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmem_addr_reg  <= `BCB_DADDR_RESET;
      dmem_rd_reg    <= 1'b0;
      dmem_wr_reg    <= 1'b0;
      data_reg       <= `BCB_DATA_RESET;
      dmem_wdata_reg <= `BCB_DATA_RESET;
    end else begin
      dmem_rd_reg <= dmem_rd_next;
      dmem_wr_reg <= dmem_wr_next;
      if (ph1 & bcf_in)
        dmem_addr_reg <= ai.addr;
      if (ph2)
        data_reg <= dmem_rdata;
      if (ph3)
        dmem_wdata_reg <= data_reg & clr_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter and the idle cycle of a taken branch.

  logic [`BCB_PC_W-1:0]  pc_next_reg;
  logic                  pc_load_reg;
  logic                  status_we_reg;

  // Neither bit-clear nor any branch here ever writes the status flags.
  wire status_we_next = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_next_reg   <= `BCB_PC_RESET;
      pc_load_reg   <= 1'b0;
      nop_reg       <= 1'b0;
      status_we_reg <= 1'b0;
    end else begin
      status_we_reg <= status_we_next;
      pc_load_reg   <= ph4 & taken;
      if (ph4) begin
        nop_reg <= taken;
        if (is_br)
          pc_next_reg <= taken ? target : pc_base_reg;
      end
    end
  end

  assign q_phase    = q_reg;
  assign dmem_addr  = dmem_addr_reg;
  assign dmem_rd    = dmem_rd_reg;
  assign dmem_wr    = dmem_wr_reg;
  assign dmem_wdata = dmem_wdata_reg;
  assign pc_next    = pc_next_reg;
  assign pc_load    = pc_load_reg;
  assign nop_cycle  = nop_reg;
  assign status_we  = status_we_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  a_bcf_clear_bit: assert property (
    @(posedge clk) disable iff (!rst_n)
    dmem_wr |-> ((dmem_wdata & ~clr_mask) == 8'h00)
                && ((dmem_wdata | ~clr_mask) == (data_reg | ~clr_mask)))
    else $error("Bit clear wrote a wrong value.");

  a_bank_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph1 && !nop_reg && instr[15:12] == `BCB_OP_BIT_CLEAR
         && instr[`BCB_ACCESS_BIT])
    |=> dmem_addr == {$past(bank_select_register), $past(instr[7:0])})
    else $error("Banked address is wrong.");

  a_indexed_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph1 && !nop_reg && instr[15:12] == `BCB_OP_BIT_CLEAR
         && !instr[`BCB_ACCESS_BIT] && ext_en
         && instr[7:0] <= `BCB_IDX_MAX)
    |=> dmem_addr == $past(fsr2) + {4'h0, $past(instr[7:0])})
    else $error("Indexed address is wrong.");

  a_status_kept: assert property (
    @(posedge clk) disable iff (!rst_n)
    !status_we)
    else $error("Status flags were written.");

  a_br_negative: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph4 && hi == `BCB_OP_BRANCH_NEG) |=> pc_load == $past(fn))
    else $error("Branch on negative decided wrongly.");

  a_br_no_carry: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph4 && hi == `BCB_OP_BRANCH_NO_C) |=> pc_load == !$past(fc))
    else $error("Branch on no carry decided wrongly.");

  a_br_not_negative: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph4 && hi == `BCB_OP_BRANCH_NOT_NEG) |=> pc_load == !$past(fn))
    else $error("Branch on not negative decided wrongly.");

  a_br_no_overflow: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph4 && hi == `BCB_OP_BRANCH_NO_OV) |=> pc_load == !$past(fv))
    else $error("Branch on no overflow decided wrongly.");

  a_br_nonzero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph4 && hi == `BCB_OP_BRANCH_NONZERO) |=> pc_load == !$past(fz))
    else $error("Branch on nonzero decided wrongly.");

  a_branch_target: assert property (
    @(posedge clk) disable iff (!rst_n)
    pc_load |-> pc_next == pc_base_reg + br_off)
    else $error("Branch target is wrong.");

  a_taken_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    pc_load |-> (nop_cycle && !dmem_wr)[*4] ##1 !nop_cycle)
    else $error("Taken branch idle cycle is wrong.");

  a_not_taken: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph4 && is_br && !taken)
    |=> !pc_load && !nop_cycle && pc_next == $past(pc_base_reg))
    else $error("Untaken branch did not fall through.");

  a_bcf_phases: assert property (
    @(posedge clk) disable iff (!rst_n)
    dmem_rd |-> q_reg == BCB_Q2 ##1 (q_reg == BCB_Q3 && !dmem_wr)
                ##1 (dmem_wr && q_reg == BCB_Q4))
    else $error("Bit clear phases out of order.");

  a_rd_one_shot: assert property (
    @(posedge clk) disable iff (!rst_n)
    dmem_rd |=> !dmem_rd)
    else $error("Read strobe lasted more than one clock.");

  a_wr_one_shot: assert property (
    @(posedge clk) disable iff (!rst_n)
    dmem_wr |=> !dmem_wr)
    else $error("Write strobe lasted more than one clock.");

  a_rd_for_bcf: assert property (
    @(posedge clk) disable iff (!rst_n)
    dmem_rd |-> is_bcf)
    else $error("Read strobe without a bit clear.");

  a_wr_for_bcf: assert property (
    @(posedge clk) disable iff (!rst_n)
    dmem_wr |-> (is_bcf && ph4))
    else $error("Write strobe outside a bit clear write phase.");

  a_phase_cycle: assert property (
    @(posedge clk) disable iff (!rst_n)
    ph1 |=> ph2 ##1 ph3 ##1 ph4 ##1 ph1)
    else $error("Phases left their order.");

  a_idle_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    nop_cycle |-> (!dmem_rd && !dmem_wr))
    else $error("Memory touched in the idle cycle.");

  a_load_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    pc_load |-> (ph1 && nop_cycle) ##1 !pc_load)
    else $error("Branch load pulse misplaced.");

  a_taken_enters: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph4 && taken) |=> (pc_load && nop_cycle))
    else $error("Taken branch did not start its idle cycle.");

  a_pc_only_branch: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(ph4 && is_br) |=> $stable(pc_next))
    else $error("Program counter changed outside a branch.");

  a_idle_ignores: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ph1 && nop_reg) |=> (ir_reg == `BCB_OP_NOP))
    else $error("Idle cycle decoded a real instruction.");

endmodule // bcb_exec

// File: verif/testbench.sv
// Self-checking bench for the bit-clear and conditional branch block.
`timescale 1ns/10ps
`include "bcb_map.svh"
module testbench
  import bcb_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        ext_en = 1'b0;
  logic [3:0]  bank_select_register = 4'h7;
  logic [11:0] fsr2 = 12'h3A5;
  logic        flag_n = 1'b0;
  logic        flag_ov = 1'b0;
  logic        flag_c = 1'b0;
  logic        flag_z = 1'b0;
  logic [20:0] pc_inc = 21'h000000;
  logic [7:0]  dmem_rdata = 8'h00;
  logic [1:0]  q_phase;
  logic [11:0] dmem_addr;
  logic        dmem_rd;
  logic        dmem_wr;
  logic [7:0]  dmem_wdata;
  logic [20:0] pc_next;
  logic        pc_load;
  logic        nop_cycle;
  logic        status_we;
  logic [20:0] pc_exp = 21'h000000;
  logic [7:0]  ops [5] = '{8'hE6, 8'hE3, 8'hE7, 8'hE5, 8'hE1};
  integer      seed = 32'h4ACC;
  int          failures = 0;
  int          samples_checked = 0;

  bcb_exec dut (.clk(clk), .rst_n(rst_n), .instr(instr), .ext_en(ext_en),
    .bank_select_register(bank_select_register), .fsr2(fsr2),
    .flag_n(flag_n), .flag_ov(flag_ov), .flag_c(flag_c), .flag_z(flag_z),
    .pc_inc(pc_inc), .dmem_rdata(dmem_rdata), .q_phase(q_phase),
    .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
    .dmem_wdata(dmem_wdata), .pc_next(pc_next), .pc_load(pc_load),
    .nop_cycle(nop_cycle), .status_we(status_we));

  always #10 clk = ~clk;

////////////////////////////////////////////////////////////////////////////////
  function automatic logic taken(input logic [15:0] w);
    case (w[15:8])
      8'hE6: return flag_n;
      8'hE3: return !flag_c;
      8'hE7: return !flag_n;
      8'hE5: return !flag_ov;
      8'hE1: return !flag_z;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [11:0] exp_addr(input logic [15:0] w);
    if (!w[8] && ext_en && w[7:0] <= 8'h5F) return fsr2 + {4'h0, w[7:0]};
    if (w[8]) return {bank_select_register, w[7:0]};
    return {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
  endfunction

  task automatic chk_bus(input string nm, input logic [20:0] e,
                         input logic [20:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask

  // Entered and left at the falling edge inside Q1.
  task automatic exec(input logic [15:0] w);
    logic [7:0]  rd;
    logic [7:0]  ew;
    logic        bc;
    logic        br;
    logic        tk;
    logic [11:0] ea;
    instr = w;
    rd = 8'($random(seed));
    ew = rd & ~(8'h01 << w[11:9]);
    bc = (w[15:12] == 4'h9);
    br = w[15:8] inside {8'hE6, 8'hE3, 8'hE7, 8'hE5, 8'hE1};
    tk = br && taken(w);
    ea = exp_addr(w);
    if (br) pc_exp = tk ? pc_inc + {{12{w[7]}}, w[7:0], 1'b0} : pc_inc;
    step();
    chk_bit("dmem_rd", bc, dmem_rd);
    if (bc) chk_bus("dmem_addr", {9'h0, ea}, {9'h0, dmem_addr});
    dmem_rdata = rd;
    // Inputs change after Q1 to catch late sampling.
    {flag_n, flag_ov, flag_c, flag_z} = ~{flag_n, flag_ov, flag_c, flag_z};
    pc_inc = ~pc_inc;
    step();
    chk_bus("q_phase", 21'(BCB_Q3), {19'h0, q_phase});
    dmem_rdata = ~rd;
    step();
    chk_bit("dmem_wr", bc, dmem_wr);
    if (bc) chk_bus("dmem_wdata", {13'h0, ew}, {13'h0, dmem_wdata});
    step();
    chk_bit("status_we", 1'b0, status_we);
    chk_bit("pc_load", tk, pc_load);
    chk_bit("nop_cycle", tk, nop_cycle);
    chk_bus("pc_next", pc_exp, pc_next);
    if (tk) begin
      // A bit-clear offered in the idle cycle must be ignored.
      instr = {4'h9, 12'($random(seed))};
      for (int k = 1; k < 5; k++) begin
        step();
        chk_bit("dmem_rd", 1'b0, dmem_rd);
        chk_bit("pc_load", 1'b0, pc_load);
        chk_bit("nop_cycle", k < 4, nop_cycle);
      end
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int j = 0; j < 10; j++) begin
      {flag_n, flag_ov, flag_c, flag_z} = {4{j >= 5}};
      pc_inc = (j < 5) ? 21'h000000 : 21'h1FFFFF;
      exec({ops[j % 5], j[0] ? 8'h7F : 8'h80});
    end
    for (int k = 0; k < 8; k++) begin
      ext_en = k[2];
      exec({4'h9, 3'(k), k[1], k[0] ? 8'h60 : 8'h5F});
    end
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      {flag_n, flag_ov, flag_c, flag_z, ext_en} = r[4:0];
      bank_select_register = r[8:5];
      fsr2 = r[20:9];
      pc_inc = 21'($random(seed));
      w = 16'($random(seed));
      if (r[31:30] == 2'b00) w[15:8] = ops[r[29:27] % 5];
      else if (r[31:30] == 2'b01) w[15:12] = 4'h9;
      exec(w);
    end
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule // testbench
